/* bench/rps_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ==============================================================
// Host driver and thermistor seen through the control pin comparators
module rps_host_model (
    input wire logic clk,
    input wire logic pin_oe,
    input wire logic term,
    input wire logic fault,
    input wire logic hot,
    input wire logic cold,
    output logic ctrl_above,
    output logic hot_cmp,
    output logic cold_cmp
);
    logic junk_q = 1'h0;

    // Unbiased comparators judge nothing, so they chatter every cycle
    always_ff @(posedge clk) begin
        junk_q <= ~junk_q;
    end

    // Idle host floats the pin; fault grounds it, term low lifts it to battery
    assign ctrl_above = fault ? 1'h0 : (!term ? 1'h1 : pin_oe);
    // Thermistor thresholds only mean something while bias is driven
    assign hot_cmp = pin_oe ? hot : junk_q;
    assign cold_cmp = pin_oe ? cold : ~junk_q;
endmodule

`default_nettype wire

/* bench/tb_rx_power_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none

// ==============================================================
// Bench for the receiver supervisor
module tb_rx_power_supervisor;
    localparam int BIAS = 40;
    localparam int DGL = 8;
    localparam int PRI = 30;
    localparam int STD = 60;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [11:0] load = 12'h0000;
    logic uvlo = 1'h0;
    logic present = 1'h0;
    logic die = 1'h0;
    logic prio = 1'h1;
    logic mod_bit = 1'h0;
    logic term = 1'h1;
    logic fault = 1'h0;
    logic hot = 1'h0;
    logic cold = 1'h0;
    logic [15:0] out_p = 16'h0000;
    logic [15:0] loss_p = 16'h0000;
    logic ctrl, hot_cmp, cold_cmp, half, full, bias, pin_o, pin_oe, t_hot, t_cold;
    logic ext, f_ind, cd_ind, reg_en, ept_v, sw_a, sw_b;
    logic [12:0] lim;
    logic [7:0] ept_code;
    logic [15:0] rx_p;
    logic [1:0] mode;
    logic [11:0] lld [5] = '{12'h0064, 12'h012B, 12'h012C, 12'h012D, 12'h03E8};
    logic [11:0] rld [5] = '{12'h0032, 12'h0078, 12'h0079, 12'h0064, 12'h0063};
    logic [1:0] rex [5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h2};
    int mismatches = 0;
    int compares = 0;
    int epts = 0;
    int hi;
    int lo;

    rps_supervisor #(.BIAS_CYC(BIAS), .DEGLITCH_CYC(DGL), .MON_PRIO_CYC(PRI),
        .MON_STD_CYC(STD), .RPT_TRIM_MW(16'h0000)) u_rps_supervisor (
        .REF_CLK(clk), .RST(rst), .LOAD_CURRENT_MA(load), .RECT_ABOVE_UVLO(uvlo),
        .TX_PRESENT(present), .TEMP_HOT_CMP(hot_cmp), .TEMP_COLD_CMP(cold_cmp),
        .CTRL_ABOVE_100MV(ctrl), .DIE_OVERTEMP(die), .PRIORITY_PERIOD(prio),
        .MOD_BIT(mod_bit), .OUT_POWER_MW(out_p), .LOSS_POWER_MW(loss_p),
        .CURRENT_LIMIT_MA(lim), .RECT_HALF_SYNC(half), .RECT_FULL_SYNC(full),
        .TEMP_BIAS_WINDOW(bias), .TEMP_CTRL_PIN_O(pin_o), .TEMP_CTRL_PIN_OE(pin_oe),
        .TEMP_HOT(t_hot), .TEMP_COLD(t_cold), .EXT_CTRL_FLAG(ext), .FAULT_IND(f_ind),
        .CHARGE_DONE_IND(cd_ind), .REG_ENABLE(reg_en), .EPT_VALID(ept_v),
        .EPT_CODE(ept_code), .RX_POWER_MW(rx_p), .MODULATION_SWITCH_A(sw_a),
        .MODULATION_SWITCH_B(sw_b), .MODE(mode));

    rps_host_model u_rps_host_model (.clk(clk), .pin_oe(pin_oe), .term(term),
        .fault(fault), .hot(hot), .cold(cold), .ctrl_above(ctrl),
        .hot_cmp(hot_cmp), .cold_cmp(cold_cmp));

    // ==============================================================
    // Clock, end-power pulse counter and watchdog
    initial begin
        forever #2 clk = ~clk;
    end

    // Pulse lasts one cycle, so it is counted on the edge, not by polling
    always @(posedge clk) begin
        if (ept_v === 1'h1) epts <= epts + 1;
    end

    // Whole run is a few hundred cycles; the 20000-cycle limit cuts a hang well after that
    initial begin
        #80000;
        mismatches++;
        close_out();
    end

    // ==============================================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // Bounded wait; a timeout shows up as a mismatch on the level itself
    task automatic wait_bias(input logic lvl);
        int k;
        k = 0;
        while (bias !== lvl && k < 400) begin
            tick(1);
            k++;
        end
        check(16'(bias), 16'(lvl));
    endtask

    task automatic wait_ept(input int n, input int lim_cyc);
        int k;
        k = 0;
        while (epts == n && k < lim_cyc) begin
            tick(1);
            k++;
        end
        check(16'(epts), 16'(n + 1));
    endtask

    // Measures one full bias window and the monitor phase after it
    task automatic measure(input logic p);
        wait_bias(1'h0);
        wait_bias(1'h1);
        prio = p;
        hi = 0;
        lo = 0;
        check(16'(pin_oe), 16'h0001);
        check(16'(pin_o), 16'h0001);
        while (bias === 1'h1 && hi < 400) begin
            hi++;
            tick(1);
        end
        check(16'(pin_oe), 16'h0000);
        while (bias === 1'h0 && lo < 400) begin
            lo++;
            tick(1);
        end
    endtask

    task automatic close_out();
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==============================================================
    // Main sequence
    initial begin
        tick(10);
        rst = 1'h0;
        check(16'(lim), 16'h0190);
        check(16'({half, full, bias, mode, reg_en}), 16'h0008);
        // Lockout low keeps the rectifier in diode mode at any load
        for (int i = 0; i < 5; i++) begin
            load = lld[i];
            tick(4);
            check(16'(lim), (lld[i] < 12'h012C) ? 16'h0190 : 16'(lld[i]) + 16'h0032);
            check(16'({half, full}), 16'h0000);
        end
        uvlo = 1'h1;
        for (int i = 0; i < 5; i++) begin
            load = rld[i];
            tick(4);
            check(16'({half, full}), 16'(rex[i]));
        end
        measure(1'h1);
        check(16'(hi), 16'(BIAS));
        check(16'(lo), 16'(PRI));
        measure(1'h0);
        check(16'(hi), 16'(BIAS));
        check(16'(lo), 16'(STD));
        // Short hot glitch is filtered, a long one gets through
        tick(2);
        hot = 1'h1;
        tick(5);
        hot = 1'h0;
        tick(4);
        check(16'(t_hot), 16'h0000);
        hot = 1'h1;
        tick(DGL + 4);
        check(16'(t_hot), 16'h0001);
        hot = 1'h0;
        cold = 1'h1;
        tick(DGL + 4);
        check(16'(t_cold), 16'h0001);
        cold = 1'h0;
        wait_bias(1'h0);
        wait_bias(1'h1);
        tick(DGL + 4);
        check(16'({t_hot, t_cold}), 16'h0000);
        // Power transfer, modulation and reporting
        present = 1'h1;
        tick(6);
        check(16'({mode, reg_en}), 16'h0003);
        mod_bit = 1'h1;
        tick(4);
        check(16'({sw_a, sw_b}), 16'h0003);
        out_p = 16'h03E8;
        loss_p = 16'h00C8;
        tick(4);
        check(rx_p, 16'h04B0);
        out_p = 16'hFFF0;
        loss_p = 16'h0020;
        tick(4);
        check(rx_p, 16'hFFFF);
        die = 1'h1;
        wait_ept(0, 10);
        tick(2);
        check(16'(ept_code), 16'h0002);
        check(16'({mode, reg_en, sw_a, sw_b}), 16'h0010);
        die = 1'h0;
        uvlo = 1'h0;
        tick(6);
        check(16'(mode), 16'h0000);
        uvlo = 1'h1;
        tick(6);
        term = 1'h0;
        wait_ept(1, 200);
        tick(2);
        check(16'({ept_code, cd_ind, ext}), 16'h0007);
        term = 1'h1;
        uvlo = 1'h0;
        tick(6);
        check(16'({cd_ind, ext}), 16'h0000);
        uvlo = 1'h1;
        tick(6);
        fault = 1'h1;
        wait_ept(2, 200);
        tick(2);
        check(16'({ept_code, f_ind}), 16'h0007);
        fault = 1'h0;
        uvlo = 1'h0;
        // Let the biased pin clear the deglitched ground before power returns
        tick(12);
        uvlo = 1'h1;
        tick(6);
        check(16'(mode), 16'h0001);
        present = 1'h0;
        tick(6);
        check(16'(mode), 16'h0002);
        check(16'(epts), 16'h0003);
        close_out();
    end
endmodule

`default_nettype wire

/* core/rps_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none

// ==============================================================
// Deglitch filter: output follows input after it has held steady
module rps_deglitch #(
    parameter int CYC = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic active,
    input wire logic din,
    output logic dout
);
    logic [31:0] cnt_q;
    logic dout_q;
    wire agree = (din == dout_q);
    wire expire = (cnt_q >= 32'(CYC - 1));

    // Count only while sampling; disagreement outside the window is dropped
    always_ff @(posedge clk) begin
        if (rst || !active || agree) begin
            cnt_q <= 32'h0000_0000;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dout_q <= 1'b0;
        end else if (active && !agree && expire) begin
            dout_q <= din;
        end
    end

    assign dout = dout_q;
endmodule

// ==============================================================
// Receiver supervisor
module rps_supervisor #(
    parameter int BIAS_CYC = rps_pkg::BIAS_CYC,
    parameter int DEGLITCH_CYC = rps_pkg::DEGLITCH_CYC,
    parameter int MON_PRIO_CYC = rps_pkg::MON_PRIO_CYC,
    parameter int MON_STD_CYC = rps_pkg::MON_STD_CYC,
    parameter logic [15:0] RPT_TRIM_MW = 16'h0000
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [11:0] LOAD_CURRENT_MA,
    input wire logic RECT_ABOVE_UVLO,
    input wire logic TX_PRESENT,
    input wire logic TEMP_HOT_CMP,
    input wire logic TEMP_COLD_CMP,
    input wire logic CTRL_ABOVE_100MV,
    input wire logic DIE_OVERTEMP,
    input wire logic PRIORITY_PERIOD,
    input wire logic MOD_BIT,
    input wire logic [15:0] OUT_POWER_MW,
    input wire logic [15:0] LOSS_POWER_MW,
    output logic [12:0] CURRENT_LIMIT_MA,
    output logic RECT_HALF_SYNC,
    output logic RECT_FULL_SYNC,
    output logic TEMP_BIAS_WINDOW,
    output logic TEMP_CTRL_PIN_O,
    output logic TEMP_CTRL_PIN_OE,
    output logic TEMP_HOT,
    output logic TEMP_COLD,
    output logic EXT_CTRL_FLAG,
    output logic FAULT_IND,
    output logic CHARGE_DONE_IND,
    output logic REG_ENABLE,
    output logic EPT_VALID,
    output logic [7:0] EPT_CODE,
    output logic [15:0] RX_POWER_MW,
    output logic MODULATION_SWITCH_A,
    output logic MODULATION_SWITCH_B,
    output logic [1:0] MODE
);

    // ==============================================================
    // Input synchronisers: every input pin but REF_CLK and RST passes two flops
    logic [11:0] iout_m_q, iout_q;
    logic [15:0] pout_m_q, pout_q, ploss_m_q, ploss_q;
    logic [8:0] bits_m_q, bits_q;

    always_ff @(posedge REF_CLK) begin
        iout_m_q <= LOAD_CURRENT_MA;
        iout_q <= iout_m_q;
        pout_m_q <= OUT_POWER_MW;
        pout_q <= pout_m_q;
        ploss_m_q <= LOSS_POWER_MW;
        ploss_q <= ploss_m_q;
        bits_m_q <= {RECT_ABOVE_UVLO, TX_PRESENT, TEMP_HOT_CMP, TEMP_COLD_CMP,
            CTRL_ABOVE_100MV, DIE_OVERTEMP, PRIORITY_PERIOD, MOD_BIT, 1'b0};
        bits_q <= bits_m_q;
    end

    wire uvlo_ok = bits_q[8];
    wire present = bits_q[7];
    wire hot_raw = bits_q[6];
    wire cold_raw = bits_q[5];
    wire ctrl_hi = bits_q[4];
    wire die_hot = bits_q[3];
    wire prio = bits_q[2];
    wire mod_bit = bits_q[1];
    wire [12:0] iout = {1'b0, iout_q};

    // ==============================================================
    // Adaptive communication limit
    wire [12:0] ilim_d = (iout < rps_pkg::ILIM_KNEE_MA) ? rps_pkg::ILIM_FIXED_MA
        : iout + rps_pkg::ILIM_MARGIN_MA;
    logic [12:0] ilim_q;

    always_ff @(posedge REF_CLK) begin
        if (RST) ilim_q <= rps_pkg::ILIM_FIXED_MA;
        else ilim_q <= ilim_d;
    end

    // ==============================================================
    // Rectifier mode with hysteresis between 100 and 120 mA
    rps_pkg::rps_rect_t rect_q, rect_d;
    logic half_q, full_q;
    // Mode pins are registered from the next state so they track rect_q without decode
    wire half_d = (rect_d == rps_pkg::RPS_HALF);
    wire full_d = (rect_d == rps_pkg::RPS_FULL);

    always_comb begin
        rect_d = rect_q;
        unique case (rect_q)
            rps_pkg::RPS_DIODE: if (uvlo_ok) rect_d = rps_pkg::RPS_HALF;
            rps_pkg::RPS_HALF: if (iout > rps_pkg::SYNC_ON_MA) rect_d = rps_pkg::RPS_FULL;
            rps_pkg::RPS_FULL: if (iout < rps_pkg::SYNC_OFF_MA) rect_d = rps_pkg::RPS_HALF;
            default: rect_d = rps_pkg::RPS_DIODE;
        endcase
        if (!uvlo_ok) rect_d = rps_pkg::RPS_DIODE;
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rect_q <= rps_pkg::RPS_DIODE;
            half_q <= 1'b0;
            full_q <= 1'b0;
        end else begin
            rect_q <= rect_d;
            half_q <= half_d;
            full_q <= full_d;
        end
    end

    // ==============================================================
    // Sampling sequence: bias window, then control-pin monitor, repeat
    rps_pkg::rps_seq_t seq_q;
    logic [31:0] seq_cnt_q;
    logic [31:0] mon_len_q;
    logic bias_q;
    wire bias_end = (seq_q == rps_pkg::RPS_BIAS) && (seq_cnt_q == 32'(BIAS_CYC - 1));
    wire mon_end = (seq_q == rps_pkg::RPS_MONITOR) && (seq_cnt_q == mon_len_q - 32'h0000_0001);
    wire [31:0] mon_len_d = prio ? 32'(MON_PRIO_CYC) : 32'(MON_STD_CYC);

    // Length is latched at the monitor start so a mid-period change cannot truncate it
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            seq_q <= rps_pkg::RPS_BIAS;
            seq_cnt_q <= 32'h0000_0000;
            mon_len_q <= 32'(MON_STD_CYC);
            bias_q <= 1'b1;
        end else if (bias_end) begin
            seq_q <= rps_pkg::RPS_MONITOR;
            seq_cnt_q <= 32'h0000_0000;
            mon_len_q <= mon_len_d;
            bias_q <= 1'b0;
        end else if (mon_end) begin
            seq_q <= rps_pkg::RPS_BIAS;
            seq_cnt_q <= 32'h0000_0000;
            bias_q <= 1'b1;
        end else begin
            seq_cnt_q <= seq_cnt_q + 32'h0000_0001;
        end
    end

    wire in_bias = (seq_q == rps_pkg::RPS_BIAS);
    wire in_mon = (seq_q == rps_pkg::RPS_MONITOR);
    // The synchronised pin still shows our own bias drive for the first monitor cycles
    wire mon_settled = in_mon && (seq_cnt_q >= 32'(rps_pkg::SYNC_LAG_CYC));

    // ==============================================================
    // Temperature and pin-ground comparators, deglitched only while biased
    logic hot_f, cold_f, gnd_f;

    rps_deglitch #(.CYC(DEGLITCH_CYC)) u_hot (
        .clk(REF_CLK), .rst(RST), .active(in_bias), .din(hot_raw), .dout(hot_f));
    rps_deglitch #(.CYC(DEGLITCH_CYC)) u_cold (
        .clk(REF_CLK), .rst(RST), .active(in_bias), .din(cold_raw), .dout(cold_f));
    // A host holding the pin at ground reads as below 100 mV even with bias on
    rps_deglitch #(.CYC(DEGLITCH_CYC)) u_gnd (
        .clk(REF_CLK), .rst(RST), .active(in_bias), .din(!ctrl_hi), .dout(gnd_f));

    // ==============================================================
    // External control detection and host indications
    logic ext_q, fault_q, done_q;
    rps_pkg::rps_mode_t mode_q, mode_d;
    wire ext_set = mon_settled && ctrl_hi;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ext_q <= 1'b0;
            fault_q <= 1'b0;
            done_q <= 1'b0;
        end else if (mode_q == rps_pkg::RPS_STARTUP) begin
            ext_q <= 1'b0;
            fault_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            ext_q <= ext_q | ext_set;
            done_q <= done_q | ext_set;
            fault_q <= fault_q | gnd_f;
        end
    end

    // ==============================================================
    // Mode machine and end-power message
    logic [7:0] ept_code_q, ept_code_d;
    logic ept_valid_q;
    wire terminate_req = die_hot || ext_set || gnd_f || hot_f || cold_f;

    // Internal fault outranks the host request and the thermistor
    assign ept_code_d = die_hot ? rps_pkg::EPT_INTERNAL_FAULT
        : ext_set ? rps_pkg::EPT_CHARGE_DONE
        : rps_pkg::EPT_OVER_TEMP;

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            rps_pkg::RPS_STARTUP: if (present && uvlo_ok) mode_d = rps_pkg::RPS_POWER;
            rps_pkg::RPS_POWER: begin
                if (!present || !uvlo_ok || terminate_req) mode_d = rps_pkg::RPS_TERMINATE;
            end
            rps_pkg::RPS_TERMINATE: if (!uvlo_ok) mode_d = rps_pkg::RPS_STARTUP;
            default: mode_d = rps_pkg::RPS_STARTUP;
        endcase
    end

    wire send_ept = (mode_q == rps_pkg::RPS_POWER) && present && uvlo_ok && terminate_req;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            mode_q <= rps_pkg::RPS_STARTUP;
            ept_valid_q <= 1'b0;
            ept_code_q <= 8'h00;
        end else begin
            mode_q <= mode_d;
            ept_valid_q <= send_ept;
            if (send_ept) ept_code_q <= ept_code_d;
        end
    end

    // ==============================================================
    // Received power and modulation
    // Two carry bits: three full-scale terms would wrap a 17-bit sum
    wire [17:0] rx_sum = {2'b00, pout_q} + {2'b00, ploss_q} + {2'b00, RPT_TRIM_MW};
    logic [15:0] rx_pwr_q;
    logic mod_q, reg_en_q;
    wire talking = (mode_q != rps_pkg::RPS_TERMINATE) && uvlo_ok;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rx_pwr_q <= 16'h0000;
            mod_q <= 1'b0;
            reg_en_q <= 1'b0;
        end else begin
            rx_pwr_q <= (rx_sum[17:16] != 2'b00) ? 16'hFFFF : rx_sum[15:0];
            mod_q <= talking && mod_bit;
            reg_en_q <= (mode_d == rps_pkg::RPS_POWER) && !die_hot;
        end
    end

    // ==============================================================
    // Outputs, all flop driven
    assign CURRENT_LIMIT_MA = ilim_q;
    assign RECT_HALF_SYNC = half_q;
    assign RECT_FULL_SYNC = full_q;
    assign TEMP_BIAS_WINDOW = bias_q;
    assign TEMP_CTRL_PIN_O = bias_q;
    assign TEMP_CTRL_PIN_OE = bias_q;
    assign TEMP_HOT = hot_f;
    assign TEMP_COLD = cold_f;
    assign EXT_CTRL_FLAG = ext_q;
    assign FAULT_IND = fault_q;
    assign CHARGE_DONE_IND = done_q;
    assign REG_ENABLE = reg_en_q;
    assign EPT_VALID = ept_valid_q;
    assign EPT_CODE = ept_code_q;
    assign RX_POWER_MW = rx_pwr_q;
    assign MODULATION_SWITCH_A = mod_q;
    assign MODULATION_SWITCH_B = mod_q;
    assign MODE = mode_q;

    // ==============================================================
    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_bias_done;
        in_bias && seq_cnt_q == 32'(BIAS_CYC - 1);
    endsequence

    chk_limit_low: assert property (iout < rps_pkg::ILIM_KNEE_MA |=>
        ilim_q == rps_pkg::ILIM_FIXED_MA) else $error("fixed limit wrong");
    chk_limit_high: assert property (iout >= rps_pkg::ILIM_KNEE_MA |=>
        ilim_q == $past(iout) + rps_pkg::ILIM_MARGIN_MA) else $error("tracking limit wrong");
    chk_rect_diode: assert property (!uvlo_ok |=> rect_q == rps_pkg::RPS_DIODE)
        else $error("sync active below lockout");
    chk_rect_rise: assert property (rect_q == rps_pkg::RPS_HALF && uvlo_ok
        && iout > rps_pkg::SYNC_ON_MA |=> rect_q == rps_pkg::RPS_FULL) else $error("no full");
    chk_rect_hold: assert property (rect_q == rps_pkg::RPS_FULL && uvlo_ok
        && iout >= rps_pkg::SYNC_OFF_MA |=> rect_q == rps_pkg::RPS_FULL) else $error("early drop");
    chk_bias_close: assert property (s_bias_done |=> !TEMP_BIAS_WINDOW
        && !TEMP_CTRL_PIN_OE) else $error("bias window overran");
    chk_bias_len: assert property ($rose(in_bias) |-> in_bias [*8])
        else $error("bias window too short");
    chk_mon_len: assert property (s_bias_done |=> mon_len_q ==
        ($past(prio) ? 32'(MON_PRIO_CYC) : 32'(MON_STD_CYC))) else $error("monitor length");
    chk_ext_flag: assert property (mon_settled && ctrl_hi && mode_q != rps_pkg::RPS_STARTUP
        |=> EXT_CTRL_FLAG && CHARGE_DONE_IND) else $error("external drive missed");
    chk_ept_fault: assert property (send_ept && die_hot |=> EPT_VALID
        && EPT_CODE == rps_pkg::EPT_INTERNAL_FAULT ##1 !REG_ENABLE) else $error("ept fault");
    chk_terminate: assert property (mode_q == rps_pkg::RPS_POWER && !present
        |=> mode_q == rps_pkg::RPS_TERMINATE) else $error("removal ignored");
    chk_mod_pair: assert property (MODULATION_SWITCH_A == MODULATION_SWITCH_B)
        else $error("switches differ");

    // Ground fault seen while transferring, with no higher ranked cause present
    sequence s_ground_only;
        mode_q == rps_pkg::RPS_POWER && present && uvlo_ok && gnd_f && !die_hot && !ext_set;
    endsequence

    chk_ept_ground: assert property (s_ground_only |=> EPT_VALID
        && EPT_CODE == rps_pkg::EPT_OVER_TEMP) else $error("ground fault code");
    chk_ept_done: assert property (send_ept && !die_hot && ext_set |=>
        EPT_CODE == rps_pkg::EPT_CHARGE_DONE) else $error("charge done code");
    chk_mod_quiet: assert property (mode_q == rps_pkg::RPS_TERMINATE |=>
        !MODULATION_SWITCH_A && !MODULATION_SWITCH_B) else $error("modulating in termination");
    chk_reg_off: assert property (die_hot |=> !REG_ENABLE)
        else $error("regulator on while hot");
    chk_ext_mask: assert property (in_mon && !mon_settled && mode_q != rps_pkg::RPS_STARTUP
        |=> EXT_CTRL_FLAG == $past(EXT_CTRL_FLAG)) else $error("stale bias taken as drive");

endmodule

`default_nettype wire

/* shared/rps_pkg.sv */
package rps_pkg;

    // ==============================================================
    // Clock and timing
    localparam int CLK_KHZ = 250_000;
    localparam int BIAS_MS = 24;
    localparam int DEGLITCH_MS = 10;
    localparam int MON_PRIO_MS = 35;
    localparam int MON_STD_MS = 235;
    // Pin comparator samples still carry the bias level for this many monitor cycles
    localparam int SYNC_LAG_CYC = 2;
    localparam int BIAS_CYC = BIAS_MS * CLK_KHZ;
    localparam int DEGLITCH_CYC = DEGLITCH_MS * CLK_KHZ;
    localparam int MON_PRIO_CYC = MON_PRIO_MS * CLK_KHZ;
    localparam int MON_STD_CYC = MON_STD_MS * CLK_KHZ;

    // ==============================================================
    // Current thresholds in mA
    localparam logic [12:0] ILIM_KNEE_MA = 13'h012C;
    localparam logic [12:0] ILIM_FIXED_MA = 13'h0190;
    localparam logic [12:0] ILIM_MARGIN_MA = 13'h0032;
    localparam logic [12:0] SYNC_ON_MA = 13'h0078;
    localparam logic [12:0] SYNC_OFF_MA = 13'h0064;

    // ==============================================================
    // Power reporting, mW
    localparam logic [15:0] RPT_MAX_BIAS_MW = 16'h00FA;

    // ==============================================================
    // End-power codes
    localparam logic [7:0] EPT_CHARGE_DONE = 8'h01;
    localparam logic [7:0] EPT_INTERNAL_FAULT = 8'h02;
    localparam logic [7:0] EPT_OVER_TEMP = 8'h03;

    // ==============================================================
    // States
    typedef enum logic [1:0] {RPS_STARTUP, RPS_POWER, RPS_TERMINATE} rps_mode_t;
    typedef enum logic [1:0] {RPS_DIODE, RPS_HALF, RPS_FULL} rps_rect_t;
    typedef enum logic [0:0] {RPS_BIAS, RPS_MONITOR} rps_seq_t;

endpackage
